// >>> common/pac_pkg.sv
// Package for the auxiliary control and phase detect block
// Assumes one 200 MHz clock; pins are asynchronous and all but the data bus are synchronised in rtl
package pac_pkg;
  localparam int AUX_W          = 8;
  // Auxiliary control bit positions
  localparam int AUX_RSV0_BIT   = 0;
  localparam int AUX_RSV2_BIT   = 2;
  localparam int AUX_PDOWN_BIT  = 3;
  localparam int AUX_CLOAD_BIT  = 4;
  localparam int AUX_MSELO_BIT  = 5;
  localparam int AUX_PRESO_BIT  = 6;
  localparam int AUX_CLKDIS_BIT = 7;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam int SYNC_STAGES    = 3;
  // Pump reset interval in ns and cycles at 200 MHz
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int PUMP_RST_NS    = 5;
  localparam int PUMP_RST_CYC   = (PUMP_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    PAC_MODE_PAR,
    PAC_MODE_SER,
    PAC_MODE_DIR
  } pac_mode_t;

  typedef struct packed {
    logic clk_disable;
    logic prescaler_out;
    logic modsel_out;
    logic counter_load;
    logic power_down;
    logic [2:0] reserved;
  } pac_aux_t;

  typedef struct packed {
    logic pump_up_n;
    logic pump_down_n;
  } pac_pump_t;
endpackage : pac_pkg

// >>> rtl/pac_sync.sv
// Three-stage synchroniser with agreement of the last two stages
// Assumes clk_i is the single block clock
`timescale 1ns/1ps
module pac_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o,
  output logic      rise_o,
  output logic      fall_o
);
  import pac_pkg::*;
  logic [SYNC_STAGES-1:0] sh_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_r <= '0;
    end else begin
      sh_r <= {sh_r[SYNC_STAGES-2:0], d_i};
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o    <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (sh_r[1] == sh_r[2] && sh_r[2] != q_o) begin
        q_o    <= sh_r[2];
        rise_o <= sh_r[2];
        fall_o <= ~sh_r[2];
      end
    end
  end
endmodule : pac_sync

// >>> rtl/pac_top.sv
// Auxiliary control register, diagnostic mux and phase/frequency detector
// Assumes host pins and divided clocks are asynchronous to clk_i
// What this block does
// (RULE1) Parallel mode, extras enable low: bus latched on control strobe rise.
// (RULE2) Serial mode, control strobe high: shift serial bits first-first on shift clock.
// (RULE3) Serial shift copied to active buffer on control strobe fall.
// (RULE4) Active-high bits; serial n is bus 7-n; bits 0-2 reserved; bit 7 kills clocks.
// (RULE5) Bit 3 powers down all but the programming interface; code idles only the detector and counter load.
// (RULE6) Bit 4 makes counter load continuous from selected mode source.
// (RULE7) Bit 5 routes modulus select to diagnostic pin.
// (RULE8) Bit 6 routes raw prescaler output to diagnostic pin.
// (RULE9) Detector acts on rising edges of both divided clocks.
// (RULE10) Main leading reference pulses pump down low only.
// (RULE11) Reference leading main pulses pump up low only.
// (RULE12) Pulse width follows leading-to-lagging edge offset.
// (RULE13) Integration node is NAND of pumps; lock is their AND.
// (RULE14) Auxiliary bits act only while extras enable is low.
// (RULE15) Host picks serial with direct low serial high, parallel both low.
// (RULE16) Host holds serial write strobe low during auxiliary serial loading.
// (RULE17) Pumps idle high and both-low lasts at most a reset interval.
// (RULE18) Both diagnostic selections set: prescaler output has priority.
`timescale 1ns/1ps
module pac_top (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  bus_data_i,
  input  wire logic        ctrl_wr_i,
  input  wire logic        ser_clk_i,
  input  wire logic        ser_data_i,
  input  wire logic        ser_wr_i,
  input  wire logic        direct_sel_i,
  input  wire logic        serial_sel_i,
  input  wire logic        extras_en_n_i,
  input  wire logic        main_divided_clock_i,
  input  wire logic        reference_divided_clock_i,
  input  wire logic        modulus_select_i,
  input  wire logic        prescaler_raw_i,
  output pac_pkg::pac_pump_t pump_o,
  output logic             integ_node_o,
  output logic             lock_indicator_o,
  output logic             diag_o,
  output logic             main_clk_out_o,
  output logic             ref_clk_out_o,
  output logic             power_down_o,
  output logic             counter_load_o,
  output pac_pkg::pac_mode_t mode_o
);
  import pac_pkg::*;

  logic wr_q, wr_rise, wr_fall;
  logic sck_q, sck_rise;
  logic sd_q, swr_q, dsel_q, ssel_q, een_q;
  logic fp_q, fp_rise, fc_q, fc_rise;
  logic modulus_select_q, pres_q;
  logic [7:0] shift_r;
  logic [7:0] bus_rev;
  pac_aux_t   aux_r;
  logic       up_r, dn_r;
  logic [3:0] rst_cnt_r;
  pac_aux_t   eff;
  pac_mode_t  mode_nxt;

  pac_sync u_wr   (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(ctrl_wr_i),
                   .q_o(wr_q), .rise_o(wr_rise), .fall_o(wr_fall));
  pac_sync u_sck  (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(ser_clk_i),
                   .q_o(sck_q), .rise_o(sck_rise), .fall_o());
  pac_sync u_sd   (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(ser_data_i),
                   .q_o(sd_q), .rise_o(), .fall_o());
  pac_sync u_swr  (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(ser_wr_i),
                   .q_o(swr_q), .rise_o(), .fall_o());
  pac_sync u_dsel (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(direct_sel_i),
                   .q_o(dsel_q), .rise_o(), .fall_o());
  pac_sync u_ssel (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(serial_sel_i),
                   .q_o(ssel_q), .rise_o(), .fall_o());
  pac_sync u_een  (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(extras_en_n_i),
                   .q_o(een_q), .rise_o(), .fall_o());
  pac_sync u_fp   (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(main_divided_clock_i),
                   .q_o(fp_q), .rise_o(fp_rise), .fall_o());
  pac_sync u_fc   (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(reference_divided_clock_i),
                   .q_o(fc_q), .rise_o(fc_rise), .fall_o());
  pac_sync u_modulus_select (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(modulus_select_i),
                   .q_o(modulus_select_q), .rise_o(), .fall_o());
  pac_sync u_pres (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(prescaler_raw_i),
                   .q_o(pres_q), .rise_o(), .fall_o());

  // (RULE15) Mode decode
  always_comb begin
    if (dsel_q) begin
      mode_nxt = PAC_MODE_DIR;
    end else if (ssel_q) begin
      mode_nxt = PAC_MODE_SER;
    end else begin
      mode_nxt = PAC_MODE_PAR;
    end
  end

  // (RULE2) Serial shift register
  // (RULE16) Relies on serial strobe low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_r <= AUX_RESET;
    end else if (mode_nxt == PAC_MODE_SER && wr_q && !swr_q && sck_rise) begin
      shift_r <= {sd_q, shift_r[7:1]};
    end
  end

  // (RULE4) Bus bit 7-n lands in bit n
  always_comb begin
    bus_rev = {bus_data_i[0], bus_data_i[1], bus_data_i[2], bus_data_i[3],
               bus_data_i[4], bus_data_i[5], bus_data_i[6], bus_data_i[7]};
  end

  // (RULE1) Parallel load on strobe rise
  // (RULE3) Serial capture on strobe fall
  // (RULE4) First serial bit lands in bit 0
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_r <= AUX_RESET;
    end else if (mode_nxt == PAC_MODE_PAR && wr_rise) begin
      aux_r <= bus_rev;
    end else if (mode_nxt == PAC_MODE_SER && wr_fall) begin
      aux_r <= shift_r;
    end
  end

  // (RULE14) Stored bits gated by extras enable
  always_comb begin
    eff = een_q ? AUX_RESET : aux_r;
  end

  // (RULE5) Power down holds detector idle
  // (RULE9) Edge-triggered phase detector
  // (RULE10) Main leads gives pump down
  // (RULE11) Reference leads gives pump up
  // (RULE12) Pulse lasts until lagging edge
  // (RULE17) Both set clears after reset interval
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_r      <= 1'b0;
      dn_r      <= 1'b0;
      rst_cnt_r <= '0;
    end else if (eff.power_down) begin
      up_r      <= 1'b0;
      dn_r      <= 1'b0;
      rst_cnt_r <= '0;
    end else if (up_r && dn_r) begin
      if (rst_cnt_r >= 4'(PUMP_RST_CYC - 1)) begin
        // New edge during clear is kept
        up_r      <= fc_rise;
        dn_r      <= fp_rise;
        rst_cnt_r <= '0;
      end else begin
        rst_cnt_r <= rst_cnt_r + 4'h1;
      end
    end else begin
      if (fc_rise) begin
        up_r <= 1'b1;
      end
      if (fp_rise) begin
        dn_r <= 1'b1;
      end
    end
  end

  // Registered outputs
  // (RULE13) Lock and integration node
  // (RULE18) Prescaler output wins diagnostic pin
  // (RULE6) Continuous counter load flag
  // (RULE7) Modulus select onto diagnostic
  // (RULE8) Raw prescaler onto diagnostic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pump_o           <= 2'h3;
      integ_node_o     <= 1'b0;
      lock_indicator_o <= 1'b1;
      diag_o           <= 1'b0;
      main_clk_out_o   <= 1'b0;
      ref_clk_out_o    <= 1'b0;
      power_down_o     <= 1'b0;
      counter_load_o   <= 1'b0;
      mode_o           <= PAC_MODE_PAR;
    end else begin
      pump_o.pump_up_n   <= ~(up_r && !dn_r);
      pump_o.pump_down_n <= ~(dn_r && !up_r);
      integ_node_o       <= ~(~(up_r && !dn_r) & ~(dn_r && !up_r));
      lock_indicator_o   <= ~(up_r && !dn_r) & ~(dn_r && !up_r);
      if (eff.prescaler_out) begin
        diag_o <= pres_q;
      end else if (eff.modsel_out) begin
        diag_o <= modulus_select_q;
      end else begin
        diag_o <= 1'b0;
      end
      main_clk_out_o <= eff.clk_disable ? 1'b0 : fp_q;
      ref_clk_out_o  <= eff.clk_disable ? 1'b0 : fc_q;
      power_down_o   <= eff.power_down;
      counter_load_o <= eff.counter_load & ~eff.power_down;
      mode_o         <= mode_nxt;
    end
  end

  // (RULE10) Pumps never both low
  property p_pump_excl;
    @(posedge clk_i) disable iff (!rst_n_i)
      !(pump_o.pump_up_n == 1'b0 && pump_o.pump_down_n == 1'b0);
  endproperty
  a_pump_excl: assert property (p_pump_excl) else $error("both pumps low"); // RULE10

  // (RULE13) Lock equals AND of pumps
  property p_lock;
    @(posedge clk_i) disable iff (!rst_n_i)
      lock_indicator_o == (pump_o.pump_up_n & pump_o.pump_down_n);
  endproperty
  a_lock: assert property (p_lock) else $error("lock not AND of pumps"); // RULE13

  // (RULE13) Node is NAND of pumps
  property p_node;
    @(posedge clk_i) disable iff (!rst_n_i)
      integ_node_o == ~(pump_o.pump_up_n & pump_o.pump_down_n);
  endproperty
  a_node: assert property (p_node) else $error("node not NAND of pumps"); // RULE13

  // (RULE11) Reference edge alone starts pump up
  property p_up_start;
    @(posedge clk_i) disable iff (!rst_n_i)
      (fc_rise && !fp_rise && !up_r && !dn_r && !eff.power_down) |=> ##1 !pump_o.pump_up_n;
  endproperty
  a_up_start: assert property (p_up_start) else $error("pump up missing"); // RULE11

  // (RULE10) Main edge alone starts pump down
  property p_dn_start;
    @(posedge clk_i) disable iff (!rst_n_i)
      (fp_rise && !fc_rise && !up_r && !dn_r && !eff.power_down) |=> ##1 !pump_o.pump_down_n;
  endproperty
  a_dn_start: assert property (p_dn_start) else $error("pump down missing"); // RULE10

  // (RULE17) Both-set state bounded
  property p_rst_bound;
    @(posedge clk_i) disable iff (!rst_n_i)
      (up_r && dn_r) |-> ##[1:2] !(up_r && dn_r);
  endproperty
  a_rst_bound: assert property (p_rst_bound) else $error("pump reset too long"); // RULE17

  // (RULE1) Parallel strobe rise loads bus
  property p_par_load;
    @(posedge clk_i) disable iff (!rst_n_i)
      (mode_nxt == PAC_MODE_PAR && wr_rise) |=> (aux_r == $past(bus_rev));
  endproperty
  a_par_load: assert property (p_par_load) else $error("parallel load missed"); // RULE1

  // (RULE3) Active bits stable while shifting
  property p_ser_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      (mode_nxt == PAC_MODE_SER && !wr_fall) |=> $stable(aux_r);
  endproperty
  a_ser_hold: assert property (p_ser_hold) else $error("serial changed active bits"); // RULE3

  // (RULE4) Clock disable forces outputs low
  property p_clkdis;
    @(posedge clk_i) disable iff (!rst_n_i)
      eff.clk_disable |=> (!main_clk_out_o && !ref_clk_out_o);
  endproperty
  a_clkdis: assert property (p_clkdis) else $error("clock outputs not disabled"); // RULE4

  // (RULE14) Extras disabled hides bits
  property p_een;
    @(posedge clk_i) disable iff (!rst_n_i)
      een_q |=> (!diag_o && !counter_load_o && !power_down_o);
  endproperty
  a_een: assert property (p_een) else $error("aux active while disabled"); // RULE14
endmodule : pac_top

// >>> bench/pac_host.sv
// Host controller model driving the parallel and serial programming pins
// Assumes the bench calls its tasks; pins change on the falling clock edge
`timescale 1ns/1ps
module pac_host (
  input  wire logic       clk_i,
  output logic [7:0]      bus_data_o,
  output logic            ctrl_wr_o,
  output logic            ser_clk_o,
  output logic            ser_data_o,
  output logic            ser_wr_o,
  output logic            direct_sel_o,
  output logic            serial_sel_o
);
  initial begin
    bus_data_o   = 8'h00;
    ctrl_wr_o    = 1'b0;
    ser_clk_o    = 1'b0;
    ser_data_o   = 1'b0;
    ser_wr_o     = 1'b0;
    direct_sel_o = 1'b0;
    serial_sel_o = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : idle
  task automatic set_mode(input logic dir, input logic ser);
    direct_sel_o = dir;
    serial_sel_o = ser;
    idle(6);
  endtask : set_mode
  task automatic par_write(input logic [7:0] v);
    set_mode(1'b0, 1'b0);
    bus_data_o = v;
    idle(6);
    ctrl_wr_o = 1'b1;
    idle(8);
    ctrl_wr_o = 1'b0;
    idle(6);
    bus_data_o = ~v;
  endtask : par_write
  // serial shift, bus bit 7 first
  task automatic ser_shift(input logic [7:0] v, input logic hold_wr);
    set_mode(1'b0, 1'b1);
    ser_wr_o  = hold_wr;
    ctrl_wr_o = 1'b1;
    idle(6);
    for (int i = 7; i >= 0; i--) begin
      ser_data_o = v[i];
      idle(6);
      ser_clk_o = 1'b1;
      idle(6);
      ser_clk_o = 1'b0;
    end
    ser_data_o = ~v[0];
  endtask : ser_shift
  task automatic ser_capture;
    ctrl_wr_o = 1'b0;
    ser_wr_o  = 1'b0;
    idle(8);
  endtask : ser_capture
endmodule : pac_host

// >>> bench/tb_top.sv
// Self-checking bench for the auxiliary control and phase detect block
// Assumes pac_host drives the programming pins and the bench the rest
`timescale 1ns/1ps
module tb_top;
  import pac_pkg::*;
  `define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s exp %0h got %0h", nm, exp, got); end end
  logic       clk_i, rst_n_i, extras_en_n_i, mdc, rdc, modulus_select, praw;
  logic [7:0] bus_data;
  logic       ctrl_wr, ser_clk, ser_data, ser_wr, dsel, ssel;
  pac_pump_t  pump;
  logic       integ, lock, diag, mco, rco, pd, cl;
  pac_mode_t  mode;
  int         err_total, check_count, w1, w2, wo;
  pac_host pac_host_inst (.clk_i(clk_i), .bus_data_o(bus_data), .ctrl_wr_o(ctrl_wr),
    .ser_clk_o(ser_clk), .ser_data_o(ser_data), .ser_wr_o(ser_wr), .direct_sel_o(dsel),
    .serial_sel_o(ssel));
  pac_top pac_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_data_i(bus_data),
    .ctrl_wr_i(ctrl_wr), .ser_clk_i(ser_clk), .ser_data_i(ser_data), .ser_wr_i(ser_wr),
    .direct_sel_i(dsel), .serial_sel_i(ssel), .extras_en_n_i(extras_en_n_i),
    .main_divided_clock_i(mdc), .reference_divided_clock_i(rdc), .modulus_select_i(modulus_select),
    .prescaler_raw_i(praw), .pump_o(pump), .integ_node_o(integ), .lock_indicator_o(lock),
    .diag_o(diag), .main_clk_out_o(mco), .ref_clk_out_o(rco), .power_down_o(pd),
    .counter_load_o(cl), .mode_o(mode));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic close_out;
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // Leader rises, lagger follows after ofs+1 cycles; w counts leader pump low cycles
  task automatic phase(input logic ref_first, input int ofs, output int w);
    w  = 0;
    wo = 0;
    if (ref_first) rdc = 1'b1;
    else mdc = 1'b1;
    for (int i = 0; i < ofs + 20; i++) begin
      @(negedge clk_i);
      if (i == ofs) begin
        rdc = 1'b1;
        mdc = 1'b1;
      end
      if ((ref_first ? pump.pump_up_n : pump.pump_down_n) === 1'b0) w++;
      if ((ref_first ? pump.pump_down_n : pump.pump_up_n) === 1'b0) wo++;
      if (i == ofs / 2 + 4) begin
        `CHK("lock", 1'b0, lock)
        `CHK("node", 1'b1, integ)
      end
    end
    `CHK("other pump", 0, wo)
    `CHK("pumps idle", 2'b11, pump)
    rdc = 1'b0;
    mdc = 1'b0;
    cyc(10);
  endtask : phase
  initial begin
    {rst_n_i, extras_en_n_i, mdc, rdc, modulus_select, praw} = 6'h00;
    err_total = 0;
    check_count = 0;
    cyc(20);
    rst_n_i = 1'b1;
    cyc(10);
    `CHK("pumps", 2'b11, pump)
    `CHK("lock", 1'b1, lock)
    `CHK("pd", 1'b0, pd)
    pac_host_inst.par_write(8'h10);
    `CHK("pd", 1'b1, pd)
    extras_en_n_i = 1'b1;
    cyc(10);
    `CHK("pd masked", 1'b0, pd)
    extras_en_n_i = 1'b0;
    cyc(10);
    `CHK("pd kept", 1'b1, pd)
    pac_host_inst.par_write(8'h08);
    `CHK("cl", 1'b1, cl)
    `CHK("pd", 1'b0, pd)
    pac_host_inst.par_write(8'h04);
    modulus_select = 1'b1;
    cyc(8);
    `CHK("diag modulus_select", 1'b1, diag)
    modulus_select = 1'b0;
    cyc(8);
    `CHK("diag modulus_select", 1'b0, diag)
    pac_host_inst.par_write(8'h06);
    modulus_select = 1'b1;
    cyc(8);
    `CHK("diag prio", 1'b0, diag)
    praw = 1'b1;
    cyc(8);
    `CHK("diag raw", 1'b1, diag)
    pac_host_inst.par_write(8'h01);
    rdc = 1'b1;
    mdc = 1'b1;
    cyc(10);
    `CHK("clk off", 2'b00, {mco, rco})
    pac_host_inst.par_write(8'h00);
    `CHK("clk on", 2'b11, {mco, rco})
    rdc = 1'b0;
    mdc = 1'b0;
    cyc(10);
    pac_host_inst.ser_shift(8'h08, 1'b0);
    `CHK("cl early", 1'b0, cl)
    `CHK("pd early", 1'b0, pd)
    pac_host_inst.ser_capture();
    `CHK("cl serial", 1'b1, cl)
    `CHK("pd serial", 1'b0, pd)
    `CHK("mode", PAC_MODE_SER, mode)
    pac_host_inst.ser_shift(8'h10, 1'b1);
    pac_host_inst.ser_capture();
    `CHK("swr cl", 1'b1, cl)
    `CHK("swr pd", 1'b0, pd)
    pac_host_inst.set_mode(1'b1, 1'b0);
    `CHK("mode", PAC_MODE_DIR, mode)
    pac_host_inst.par_write(8'h00);
    `CHK("mode", PAC_MODE_PAR, mode)
    phase(1'b1, 10, w1);
    phase(1'b1, 20, w2);
    `CHK("up width", 10, w2 - w1)
    phase(1'b0, 10, w1);
    phase(1'b0, 20, w2);
    `CHK("down width", 10, w2 - w1)
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    close_out();
  end
endmodule : tb_top
